// [common/cmp_branch_pkg.sv]
package cmp_branch_pkg;

   // ************************************************************
   // Opcode map
   // ************************************************************
   localparam logic [7:0] OP_BEQ_IMM    = 8'h31;
   localparam logic [6:0] OP_BEQ_DIR    = 7'h19;   // 32h..33h, upper seven bits
   localparam logic [5:0] OP_BEQ_IND    = 6'h0d;   // 34h..37h, upper six bits
   localparam logic [7:0] OP_BNE_IMM    = 8'h41;
   localparam logic [6:0] OP_BNE_DIR    = 7'h21;   // 42h..43h
   localparam logic [5:0] OP_BNE_IND    = 6'h11;   // 44h..47h

   // ************************************************************
   // Field positions and sizes
   // ************************************************************
   localparam int          OPC_D8_BIT    = 0;
   localparam int          OPC_J_LSB     = 0;
   localparam int          PTR_W         = 8;
   localparam int          ADDR_W        = 9;
   localparam logic [15:0] INSN_LEN      = 16'h0003;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] PC_RST        = 16'h0000;
   localparam logic [8:0]  ADDR_RST      = 9'h000;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_EXEC
   } exec_state_e;

endpackage

// [logic/operand_compare.sv]
`timescale 1ns/1ps

module operand_compare (
   input  wire logic [7:0] lhs_i,
   input  wire logic [7:0] rhs_i,
   output logic            equal_o,
   output logic            below_o
);

   assign equal_o = (lhs_i == rhs_i);
   assign below_o = (lhs_i < rhs_i);   // Unsigned on purpose

endmodule

// [logic/compare_branch_exec.sv]
`timescale 1ns/1ps


module compare_branch_exec
   import cmp_branch_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  immediate_byte_i,
   input  wire logic [7:0]  rel_offset_byte_i,
   input  wire logic [15:0] pc_i,
   input  wire logic [7:0]  acc_i,
   input  wire logic [31:0] pointer_file_i,
   input  wire logic [7:0]  mem_data_i,
   output logic             busy_o,
   output logic             mem_rd_o,
   output logic [8:0]       mem_addr_o,
   output logic             irq_window_o,
   output logic             done_o,
   output logic             taken_o,
   output logic [15:0]      pc_o,
   output logic             carry_flag_o,
   output logic             illegal_o
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_sync1_q;
   logic rst_sync2_q;

   // Assertion is immediate; release waits two edges so no flop sees a runt edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync1_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync2_q <= rst_sync1_q;
      end
   end

   wire rst_n = rst_sync2_q;

   // ************************************************************
   // Opcode decode
   // ************************************************************
   wire is_beq_imm = (opcode_i == OP_BEQ_IMM);
   wire is_beq_dir = (opcode_i[7:1] == OP_BEQ_DIR);
   wire is_beq_ind = (opcode_i[7:2] == OP_BEQ_IND);
   wire is_bne_imm = (opcode_i == OP_BNE_IMM);
   wire is_bne_dir = (opcode_i[7:1] == OP_BNE_DIR);
   wire is_bne_ind = (opcode_i[7:2] == OP_BNE_IND);

   wire is_dir   = is_beq_dir | is_bne_dir;
   wire is_ind   = is_beq_ind | is_bne_ind;
   wire is_imm   = is_beq_imm | is_bne_imm;
   wire is_eq    = is_beq_imm | is_beq_dir | is_beq_ind;
   wire is_legal = is_dir | is_ind | is_imm;

   wire [1:0]        ptr_sel = opcode_i[OPC_J_LSB +: 2];
   wire [PTR_W-1:0]  ptr_val = pointer_file_i[ptr_sel*PTR_W +: PTR_W];

   // Direct: d8 from the opcode, d7..d0 from the second byte
   wire [ADDR_W-1:0] dir_addr = {opcode_i[OPC_D8_BIT], immediate_byte_i};
   // Pointers reach the lower 256 bytes only
   wire [ADDR_W-1:0] ind_addr = {1'b0, ptr_val};
   wire [ADDR_W-1:0] op_addr  = is_dir ? dir_addr : ind_addr;

   // ************************************************************
   // Latched instruction
   // ************************************************************
   exec_state_e state_q;
   exec_state_e state_d;
   logic        eq_form_q;
   logic        imm_form_q;
   logic        ind_form_q;
   logic [7:0]  acc_q;
   logic [7:0]  imm_q;
   logic [7:0]  off_q;
   logic [15:0] next_pc_q;

   // ************************************************************
   // Sequencer
   // ************************************************************
   wire accept = (state_q == ST_IDLE) && start_i && is_legal;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;   // Exactly two cycles, no stall
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // Operand latch
   // ************************************************************
   // Everything is taken at the start, so the core may move its inputs on at once
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         eq_form_q <= 1'b0;
      end else if (accept) begin
         eq_form_q <= is_eq;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         imm_form_q <= 1'b0;
      end else if (accept) begin
         imm_form_q <= is_imm;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ind_form_q <= 1'b0;
      end else if (accept) begin
         ind_form_q <= is_ind;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 8'h00;
      end else if (accept) begin
         acc_q <= acc_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         imm_q <= 8'h00;
      end else if (accept) begin
         imm_q <= immediate_byte_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         off_q <= 8'h00;
      end else if (accept) begin
         off_q <= rel_offset_byte_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         next_pc_q <= PC_RST;
      end else if (accept) begin
         next_pc_q <= pc_i + INSN_LEN;
      end
   end

   // ************************************************************
   // Operand fetch
   // ************************************************************
   // Memory is read only, so the compared byte can never change
   wire fetch = accept && !is_imm;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_o <= 1'b0;
      end else begin
         mem_rd_o <= fetch;
      end
   end

   // The address holds after the read, so a slow memory side still sees it
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr_o <= ADDR_RST;
      end else if (fetch) begin
         mem_addr_o <= op_addr;
      end
   end

   // ************************************************************
   // Compare and branch
   // ************************************************************
   // Indirect forms put the memory byte on the left, the others the accumulator
   wire [7:0] cmp_lhs = ind_form_q ? mem_data_i : acc_q;
   wire [7:0] cmp_rhs = (imm_form_q || ind_form_q) ? imm_q : mem_data_i;
   wire       cmp_eq;
   wire       cmp_lt;

   operand_compare u_cmp (
      .lhs_i   (cmp_lhs),
      .rhs_i   (cmp_rhs),
      .equal_o (cmp_eq),
      .below_o (cmp_lt)
   );

   wire        take     = eq_form_q ? cmp_eq : !cmp_eq;
   wire [15:0] off_ext  = {{8{off_q[7]}}, off_q};
   wire [15:0] branch_pc = next_pc_q + off_ext;
   wire [15:0] dest_pc  = take ? branch_pc : next_pc_q;
   wire        finishing = (state_q == ST_EXEC);

   // ************************************************************
   // Result registers
   // ************************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         done_o <= 1'b0;
      end else begin
         done_o <= finishing;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         taken_o <= 1'b0;
      end else if (finishing) begin
         taken_o <= take;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pc_o <= PC_RST;
      end else if (finishing) begin
         pc_o <= dest_pc;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         carry_flag_o <= 1'b0;
      end else if (finishing) begin
         carry_flag_o <= cmp_lt;   // Set or cleared every time
      end
   end

   // ************************************************************
   // Status
   // ************************************************************
   wire exec_next   = (state_d == ST_EXEC);
   // Unknown opcodes are only reported; the core decides how to trap them
   wire illegal_req = (state_q == ST_IDLE) && start_i && !is_legal;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= exec_next;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         illegal_o <= 1'b0;
      end else begin
         illegal_o <= illegal_req;
      end
   end

   // ************************************************************
   // Interrupt window
   // ************************************************************
   // The window marks the second cycle only, the one where the core may vector
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_window_o <= 1'b0;
      end else begin
         irq_window_o <= accept;
      end
   end

endmodule

// [test/cmp_branch_monitor.sv]
`timescale 1ns/1ps
module cmp_branch_monitor
   import cmp_branch_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        start_i,
   input wire logic [7:0]  opcode_i,
   input wire logic [7:0]  immediate_byte_i,
   input wire logic [7:0]  rel_offset_byte_i,
   input wire logic [15:0] pc_i,
   input wire logic [7:0]  acc_i,
   input wire logic [31:0] pointer_file_i,
   input wire logic [7:0]  mem_data_i,
   input wire logic        busy_o,
   input wire logic        mem_rd_o,
   input wire logic [8:0]  mem_addr_o,
   input wire logic        irq_window_o,
   input wire logic        done_o,
   input wire logic        taken_o,
   input wire logic [15:0] pc_o,
   input wire logic        carry_flag_o,
   input wire logic        illegal_o
);
   // ****
   // Request decode
   // ****
   wire logic        go = start_i && !busy_o;
   wire logic        im = opcode_i == OP_BEQ_IMM || opcode_i == OP_BNE_IMM;
   wire logic        dr = opcode_i[7:1] == OP_BEQ_DIR || opcode_i[7:1] == OP_BNE_DIR;
   wire logic        nd = opcode_i[7:2] == OP_BEQ_IND || opcode_i[7:2] == OP_BNE_IND;
   wire logic [7:0]  pj = pointer_file_i[8*opcode_i[1:0] +: 8];
   wire logic [15:0] sx = {{8{rel_offset_byte_i[7]}}, rel_offset_byte_i};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_two_cycles: assert property (
      go && (im || dr || nd) |=> busy_o && irq_window_o ##1 done_o && !busy_o)
      else $error("request not answered in two cycles");
   a_irq_second: assert property (
      irq_window_o |-> busy_o && $past(go)) else $error("interrupt window outside cycle two");
   a_dir_addr: assert property (
      go && dr |=> mem_rd_o && mem_addr_o == {$past(opcode_i[0]), $past(immediate_byte_i)})
      else $error("wrong direct address");
   a_ind_addr: assert property (
      go && nd |=> mem_rd_o && mem_addr_o == {1'b0, $past(pj)}) else $error("wrong pointer");
   a_imm_noread: assert property (
      go && im |=> !mem_rd_o) else $error("immediate form read memory");
   a_pc_next: assert property (
      done_o |-> pc_o == $past(pc_i, 2) + INSN_LEN + (taken_o ? $past(sx, 2) : 16'h0000))
      else $error("wrong next counter");
   a_carry_acc: assert property (
      done_o && $past(im, 2) |-> carry_flag_o == ($past(acc_i, 2) < $past(immediate_byte_i, 2)))
      else $error("wrong carry");
   a_carry_ind: assert property (
      done_o && $past(nd, 2) |-> carry_flag_o == ($past(mem_data_i) < $past(immediate_byte_i, 2)))
      else $error("wrong indirect carry");
endmodule
bind compare_branch_exec cmp_branch_monitor mon (
   .clk_i             (clk_i),
   .rst_n_i           (rst_n_i),
   .start_i           (start_i),
   .opcode_i          (opcode_i),
   .immediate_byte_i  (immediate_byte_i),
   .rel_offset_byte_i (rel_offset_byte_i),
   .pc_i              (pc_i),
   .acc_i             (acc_i),
   .pointer_file_i    (pointer_file_i),
   .mem_data_i        (mem_data_i),
   .busy_o            (busy_o),
   .mem_rd_o          (mem_rd_o),
   .mem_addr_o        (mem_addr_o),
   .irq_window_o      (irq_window_o),
   .done_o            (done_o),
   .taken_o           (taken_o),
   .pc_o              (pc_o),
   .carry_flag_o      (carry_flag_o),
   .illegal_o         (illegal_o)
);

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
   import cmp_branch_pkg::*;
   logic        clk_i = 0, rst_n_i = 0, start_i = 0;
   logic [7:0]  opcode_i = 0, immediate_byte_i = 0, rel_offset_byte_i = 0, acc_i = 0;
   logic [15:0] pc_i = 0, pc_o;
   logic [31:0] pointer_file_i = 0, v;
   logic [7:0]  mem_data_i, op, i8, a, mem [512];
   logic [8:0]  mem_addr_o;
   logic        busy_o, mem_rd_o, irq_window_o, done_o, taken_o, carry_flag_o, illegal_o;
   logic [17:0] exp_q [$], note;
   logic [7:0]  ops [15] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
                             8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
   int          err_count = 0, check_count = 0, seed = 20, ill_exp = 0, ill_seen = 0;
   compare_branch_exec dut (
      .clk_i             (clk_i),
      .rst_n_i           (rst_n_i),
      .start_i           (start_i),
      .opcode_i          (opcode_i),
      .immediate_byte_i  (immediate_byte_i),
      .rel_offset_byte_i (rel_offset_byte_i),
      .pc_i              (pc_i),
      .acc_i             (acc_i),
      .pointer_file_i    (pointer_file_i),
      .mem_data_i        (mem_data_i),
      .busy_o            (busy_o),
      .mem_rd_o          (mem_rd_o),
      .mem_addr_o        (mem_addr_o),
      .irq_window_o      (irq_window_o),
      .done_o            (done_o),
      .taken_o           (taken_o),
      .pc_o              (pc_o),
      .carry_flag_o      (carry_flag_o),
      .illegal_o         (illegal_o)
   );
   always #10 clk_i = ~clk_i;
   // Released bus shows the inverse, so a late read cannot match by luck
   assign mem_data_i = mem_rd_o ? mem[mem_addr_o] : ~mem[mem_addr_o];
   // ****
   // Checking and stimulus
   // ****
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Called at a falling edge; a held start in cycle two must be ignored
   task automatic issue(input logic [7:0] o, b, r, c, input logic [15:0] p, input logic h);
      logic [7:0] lhs, rhs;
      logic       d, n, ok, t;
      n = o[7:2] == OP_BEQ_IND || o[7:2] == OP_BNE_IND;
      d = o[7:1] == OP_BEQ_DIR || o[7:1] == OP_BNE_DIR;
      ok = d || n || o == OP_BEQ_IMM || o == OP_BNE_IMM;
      lhs = n ? mem[{1'b0, pointer_file_i[8*o[1:0] +: 8]}] : c;
      rhs = d ? mem[{o[0], b}] : b;
      t = (lhs == rhs) ^ o[6];
      {start_i, opcode_i, immediate_byte_i, rel_offset_byte_i, acc_i, pc_i} = {1'b1, o, b, r, c, p};
      if (ok) exp_q.push_back({t, p + INSN_LEN + (t ? {{8{r[7]}}, r} : 16'h0000), lhs < rhs});
      else ill_exp++;
      @(negedge clk_i);
      start_i = h & ok;
      acc_i = ~c;
      pc_i = ~p;
      @(negedge clk_i);
   endtask
   // Outputs move at the rising edge, so they are read settled at the falling one
   always @(negedge clk_i) begin
      if (illegal_o === 1'b1) ill_seen++;
      if (done_o === 1'b1 && exp_q.size() == 0) begin
         check(18'h0, 18'h3ffff);
      end else if (done_o === 1'b1) begin
         note = exp_q.pop_front();
         check(18'(taken_o), 18'(note[17]));
         check(18'(pc_o), 18'(note[16:1]));
         check(18'(carry_flag_o), 18'(note[0]));
      end
   end
   initial begin
      for (int k = 0; k < 512; k++) mem[k] = 8'($random(seed));
      mem[9'h102] = 8'h02;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1;
      repeat (3) @(negedge clk_i);
      issue(8'h33, 8'h02, 8'h3f, 8'h02, 16'h0f1d, 1'b0);
      issue(8'h31, 8'h04, 8'h3f, 8'h03, 16'h0f1d, 1'b1);
      for (int n = 0; n < 300; n++) begin
         v = $random(seed);
         pointer_file_i = $random(seed);
         op = ops[n % 15];
         a = v[19:18] == 2'b00 ? {8{v[17]}} : v[7:0];
         i8 = v[15:8];
         if (v[16] && op[2]) i8 = mem[{1'b0, pointer_file_i[8*op[1:0] +: 8]}];
         else if (v[16] && op[1]) a = mem[{op[0], i8}];
         else if (v[16]) i8 = a;
         issue(op, i8, v[31:24], a, 16'($random(seed)), v[20]);
      end
      start_i = 0;
      for (int t = 0; t < 10 && exp_q.size() > 0; t++) @(negedge clk_i);
      check(18'(exp_q.size()), 18'h0);
      check(18'(ill_seen), 18'(ill_exp));
      test_done();
   end
endmodule
